// file: hdl/blc_pkg.sv
// Shared constants for the backlight control and fault logic
package blc_pkg;

  // ==========================================================
  // Sizes
  localparam int NCH = 6;
  localparam int FLT_W = 12;
  localparam int CUR_W = 12;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADR_SRC = 8'h00;
  localparam logic [7:0] ADR_BRT = 8'h04;
  localparam logic [7:0] ADR_FST = 8'h08;
  localparam logic [7:0] ADR_FEN = 8'h0c;
  localparam logic [7:0] ADR_STA = 8'h10;
  localparam logic [7:0] ADR_CUR = 8'h20;

  // ==========================================================
  // Fault status bit positions
  localparam int F_OPEN = 0;
  localparam int F_SHORT = 1;
  localparam int F_GND = 2;
  localparam int F_SYS = 3;
  localparam int F_PUMP = 11;

  // ==========================================================
  // Status register bit positions
  localparam int S_PUMP = 0;
  localparam int S_CAP = 1;
  localparam int S_EXT = 2;
  localparam int S_SS = 3;
  localparam int S_RUN = 4;
  localparam int S_CNT = 8;

  // ==========================================================
  // Reset values
  localparam logic RST_SRC = 1'b0;
  localparam logic [15:0] RST_BRT = 16'hffff;
  localparam logic [FLT_W-1:0] RST_FEN = 12'hfff;
  localparam logic [CUR_W-1:0] RST_CUR = 12'hfff;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 4;
  localparam int SYNC_DET_NS = 10000;
  localparam int SYNC_DET_CYC = SYNC_DET_NS / CLK_NS;

  typedef enum logic [1:0] {ST_OFF, ST_DETECT, ST_RUN} blc_state_type;

endpackage : blc_pkg

// file: hdl/blc_top.sv
// Backlight driver control, phase-shifted dimming and fault reporting
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Brightness follows dimming input duty by default; bus value is alternative.
// - Any enabled latched fault pulls the open-drain interrupt pin.
// - Fault status clears by bus write-one or on enable falling edge.
// - String count picks phase step 360/N between active channel PWMs.
// - Unused channels are off, out of boost loop, never flag faults.
// - Each channel has a 12-bit bus-written current scale.
// - Sync clock detected at start-up selects external boost clock.
// - Sync held high enables spread spectrum, held low disables it.
// - Blocks run only while enable is high.
// - With enable low, bus writes are ignored and no fault is raised.
// - Bus sets global brightness and reads back fault status.
// - Charge pump enabled unless supply and pump supply are tied.
// - With pump enabled, a flag reports flying capacitor detection.
// - With pump enabled, pump fault sets its status flag and asserts the interrupt.
// - Pump interrupt enable can block the interrupt; status still latches.
// - Open, short, ground, resistor, boost, supply and thermal faults recorded.
module blc_top
  import blc_pkg::*;
#(
  parameter int PWM_W = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_boost_sync_clk,
  input wire logic i_boost_sync_lvl,
  input wire logic i_en,
  input wire logic i_dim_in,
  input wire logic [2:0] i_string_count_select,
  input wire logic i_pump_tied,
  input wire logic i_pump_cap_det,
  input wire logic i_pump_fault,
  input wire logic [NCH-1:0] i_led_open,
  input wire logic [NCH-1:0] i_led_short,
  input wire logic [NCH-1:0] i_led_gnd,
  input wire logic [7:0] i_sys_fault,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic [NCH-1:0] o_sink_pwm,
  output logic [NCH-1:0] o_sink_en,
  output logic [NCH-1:0] o_boost_loop_mask,
  output logic [NCH*CUR_W-1:0] o_chan_scale,
  output logic o_fault_int_o,
  output logic o_fault_int_oe,
  output logic o_blocks_on,
  output logic o_pump_on,
  output logic o_boost_ext_clk_sel,
  output logic o_spread_on
);

  // ==========================================================
  // Reset release and input synchronisers
  localparam int SW = 36;
  logic [1:0] rst_ff;
  logic rst_n;
  logic tgl_ff;
  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  logic tgl_d_ff;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // Link domain: toggles on every rising sync edge; a missing clock just freezes it
  always_ff @(posedge i_boost_sync_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tgl_ff <= 1'b0;
    end else begin
      tgl_ff <= ~tgl_ff;
    end
  end

  // Two-stage capture of every non-bus input pin and of the link toggle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {tgl_ff, i_en, i_dim_in, i_boost_sync_lvl, i_pump_tied,
                i_pump_cap_det, i_pump_fault, i_sys_fault, i_led_gnd,
                i_led_short, i_led_open, i_string_count_select};
      s2_ff <= s1_ff;
    end
  end

  logic tgl_s, en, dim, sync_lvl, tied, cap_det, pump_flt;
  logic [7:0] sys_flt;
  logic [NCH-1:0] gnd, shrt, opn;
  logic [2:0] cnt_sel;
  assign {tgl_s, en, dim, sync_lvl, tied, cap_det, pump_flt, sys_flt, gnd,
          shrt, opn, cnt_sel} = s2_ff;

  // ==========================================================
  // Enable and start-up sequence
  blc_state_type st_ff;
  logic en_d_ff;
  logic en_fall;
  logic [11:0] det_cnt_ff;
  logic seen_ff, ext_ff, ss_ff, pump_on_ff;
  logic [2:0] strings_ff;
  logic det_end;
  logic run;

  assign en_fall = en_d_ff & ~en;
  assign det_end = (st_ff == ST_DETECT) && (det_cnt_ff == 12'(SYNC_DET_CYC - 1));
  assign run = (st_ff == ST_RUN);

  // Edge memories for enable and the link toggle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d_ff <= 1'b0;
      tgl_d_ff <= 1'b0;
    end else begin
      en_d_ff <= en;
      tgl_d_ff <= tgl_s;
    end
  end

  // Off, then a fixed window watching for sync edges, then run
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_OFF;
      det_cnt_ff <= '0;
      seen_ff <= 1'b0;
    end else if (!en) begin
      st_ff <= ST_OFF;
      det_cnt_ff <= '0;
      seen_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        ST_OFF: begin
          st_ff <= ST_DETECT;
        end
        ST_DETECT: begin
          det_cnt_ff <= det_cnt_ff + 12'h001;
          seen_ff <= seen_ff | (tgl_s ^ tgl_d_ff);
          if (det_end) begin
            st_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          st_ff <= ST_RUN;
        end
      endcase
    end
  end

  // Straps are caught once, at the end of the detect window
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ff <= 1'b0;
      ss_ff <= 1'b0;
      pump_on_ff <= 1'b0;
      strings_ff <= 3'h6;
    end else if (det_end && en) begin
      ext_ff <= seen_ff | (tgl_s ^ tgl_d_ff);
      ss_ff <= ~(seen_ff | (tgl_s ^ tgl_d_ff)) & sync_lvl;
      pump_on_ff <= ~tied;
      strings_ff <= (cnt_sel == 3'h0 || cnt_sel > 3'h6) ? 3'h6 : cnt_sel;
    end
  end

  // ==========================================================
  // Register file over Wishbone
  logic src_ff;
  logic [15:0] brt_ff;
  logic [FLT_W-1:0] fst_ff, fen_ff, flt_raw, clr;
  logic [CUR_W-1:0] cur_ff [NCH];
  logic req, wr;
  logic [31:0] wd;
  logic [31:0] rd;

  // Merge write data by byte lane
  function automatic logic [31:0] lane(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : lane

  // A write lands on the edge where the master sees ack, so a late level change still counts
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & en;
  assign wd = lane(32'h0000_0000, i_wb_dat, i_wb_sel);

  // Source select, bus brightness and fault interrupt enable
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ff <= RST_SRC;
      brt_ff <= RST_BRT;
      fen_ff <= RST_FEN;
    end else if (wr) begin
      if (i_wb_adr == ADR_SRC && i_wb_sel[0]) begin
        src_ff <= i_wb_dat[0];
      end
      if (i_wb_adr == ADR_BRT) begin
        brt_ff <= 16'(lane({16'h0000, brt_ff}, i_wb_dat, i_wb_sel));
      end
      if (i_wb_adr == ADR_FEN) begin
        fen_ff <= FLT_W'(lane({20'h00000, fen_ff}, i_wb_dat, i_wb_sel));
      end
    end
  end

  // Per-channel current scale registers
  for (genvar g = 0; g < NCH; g++) begin : g_cur
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        cur_ff[g] <= RST_CUR;
      end else if (wr && i_wb_adr == ADR_CUR + 8'(4 * g)) begin
        cur_ff[g] <= CUR_W'(lane({20'h00000, cur_ff[g]}, i_wb_dat, i_wb_sel));
      end
    end
    assign o_chan_scale[g*CUR_W +: CUR_W] = cur_ff[g];
  end

  // Read mux; unmapped offsets read zero, everything reads zero while off
  always_comb begin
    rd = 32'h0000_0000;
    if (i_wb_adr == ADR_SRC) begin
      rd[0] = src_ff;
    end else if (i_wb_adr == ADR_BRT) begin
      rd[15:0] = brt_ff;
    end else if (i_wb_adr == ADR_FST) begin
      rd[FLT_W-1:0] = fst_ff;
    end else if (i_wb_adr == ADR_FEN) begin
      rd[FLT_W-1:0] = fen_ff;
    end else if (i_wb_adr == ADR_STA) begin
      rd[S_PUMP] = pump_on_ff;
      rd[S_CAP] = pump_on_ff & cap_det;
      rd[S_EXT] = ext_ff;
      rd[S_SS] = ss_ff;
      rd[S_RUN] = run;
      rd[S_CNT +: 3] = strings_ff;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (i_wb_adr == ADR_CUR + 8'(4 * c)) begin
          rd[CUR_W-1:0] = cur_ff[c];
        end
      end
    end
  end

  // One-cycle answer to every request
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= (req && en) ? rd : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Fault capture and interrupt
  logic [NCH-1:0] act;
  logic irq_want;

  always_comb begin
    flt_raw = '0;
    flt_raw[F_OPEN] = |(opn & act);
    flt_raw[F_SHORT] = |(shrt & act);
    flt_raw[F_GND] = |(gnd & act);
    flt_raw[F_SYS +: 8] = sys_flt;
    flt_raw[F_PUMP] = pump_flt & pump_on_ff;
  end
  assign clr = (wr && i_wb_adr == ADR_FST) ? wd[FLT_W-1:0] : '0;

  // Sticky status; a new fault beats a same-cycle clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fst_ff <= '0;
    end else if (en_fall || !en) begin
      fst_ff <= '0;
    end else begin
      fst_ff <= (fst_ff & ~clr) | flt_raw;
    end
  end

  // Any status bit whose interrupt is enabled wants the pin
  assign irq_want = |(fst_ff & fen_ff);

  // Open-drain pin pulls low while any enabled status is set
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_fault_int_o <= 1'b0;
      o_fault_int_oe <= 1'b0;
    end else begin
      o_fault_int_o <= 1'b0;
      o_fault_int_oe <= irq_want;
    end
  end

  // ==========================================================
  // Dimming measurement and phase-shifted channel PWM
  logic [PWM_W-1:0] ph_ff, duty_dim_ff, duty, step;
  logic [PWM_W:0] hi_ff;

  // Phase step for N strings, the full period divided by N
  always_comb begin
    step = PWM_W'((2 ** PWM_W) / int'(strings_ff));
  end
  assign duty = src_ff ? brt_ff[PWM_W-1:0] : duty_dim_ff;

  // Input duty is averaged over one full PWM period; no divider needed
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= '0;
      hi_ff <= '0;
      duty_dim_ff <= '0;
    end else begin
      ph_ff <= ph_ff + 1'b1;
      if (&ph_ff) begin
        hi_ff <= '0;
        duty_dim_ff <= (hi_ff[PWM_W] | (&hi_ff[PWM_W-1:0] & dim)) ? '1 :
                       hi_ff[PWM_W-1:0] + PWM_W'(dim);
      end else begin
        hi_ff <= hi_ff + (PWM_W+1)'(dim);
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [PWM_W-1:0] rel;
    assign act[g] = run && (3'(g) < strings_ff);
    assign rel = ph_ff - PWM_W'(g * step);
    // Channel drive, enable and boost-loop membership
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        o_sink_pwm[g] <= 1'b0;
        o_sink_en[g] <= 1'b0;
        o_boost_loop_mask[g] <= 1'b0;
      end else begin
        o_sink_pwm[g] <= act[g] && (rel < duty);
        o_sink_en[g] <= act[g];
        o_boost_loop_mask[g] <= act[g] & ~opn[g] & ~shrt[g];
      end
    end
  end

  // Block-level outputs; blocks-on follows enable, the others are off outside run
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_blocks_on <= 1'b0;
      o_pump_on <= 1'b0;
      o_boost_ext_clk_sel <= 1'b0;
      o_spread_on <= 1'b0;
    end else begin
      o_blocks_on <= en;
      o_pump_on <= run & pump_on_ff;
      o_boost_ext_clk_sel <= run & ext_ff;
      o_spread_on <= run & ss_ff;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence det_done_s;
    det_end && en ##1 en;
  endsequence

  chk_sync_select: assert property (det_done_s |=> o_boost_ext_clk_sel == ext_ff)
    else $error("boost clock select does not follow detection");
  chk_spread_excl: assert property (o_spread_on |-> !o_boost_ext_clk_sel)
    else $error("spread spectrum on with external clock");
  chk_irq_follow: assert property (##1 o_fault_int_oe == $past(irq_want))
    else $error("interrupt pin does not track enabled status");
  chk_en_fall_clr: assert property (en_fall |=> fst_ff == '0)
    else $error("status not cleared on enable fall");
  chk_off_quiet: assert property (!en && !en_d_ff |-> fst_ff == '0 ##1 !o_fault_int_oe)
    else $error("fault raised while disabled");
  chk_pump_set: assert property (en && en_d_ff && pump_on_ff && pump_flt |=> fst_ff[F_PUMP])
    else $error("pump fault not latched");
  chk_pump_masked: assert property (fst_ff == (FLT_W'(1) << F_PUMP) && !fen_ff[F_PUMP]
      |=> !o_fault_int_oe)
    else $error("masked pump fault drove interrupt");
  chk_unused_off: assert property (run && $past(run) |-> (o_sink_en >> strings_ff) == '0)
    else $error("unused channel enabled");

endmodule : blc_top
`default_nettype wire

// file: verif/blc_host_model.sv
// Host-side model: dimming duty source and boost sync pin
`timescale 1ns/1ps
`default_nettype none
module blc_host_model #(
  parameter int PER = 256
) (
  input wire logic i_clk,
  input wire logic i_sync_run,
  input wire logic i_sync_lvl,
  input wire logic [8:0] i_duty,
  output logic o_dim = 1'b0,
  output logic o_sync
);
  int cnt = 0;
  logic ck = 1'b0;
  // ==========================================================
  // Dimming pulse train, one period of PER clocks
  always @(posedge i_clk) begin
    cnt <= (cnt + 1) % PER;
    o_dim <= (cnt < int'(i_duty));
  end
  // Sync clock free of the main clock's phase; runs only within a start-up frame
  initial begin
    #13;
    forever #40 ck = ~ck;
  end
  // Outside a frame the pin is a static strap, as a board would tie it
  assign o_sync = i_sync_run ? ck : i_sync_lvl;
endmodule : blc_host_model
`default_nettype wire

// file: verif/blc_top_tb.sv
// Self-checking bench for the backlight control and fault logic
`timescale 1ns/1ps
`default_nettype none
module blc_top_tb import blc_pkg::*; ;
  localparam int PW = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b0;
  logic sync_run = 1'b0;
  logic sync_lvl = 1'b0;
  logic pump_tied = 1'b0;
  logic cap_det = 1'b1;
  logic pump_flt = 1'b0;
  logic [2:0] strings = 3'h4;
  logic [8:0] duty = 9'h080;
  logic [NCH-1:0] led_open = '0;
  logic [NCH-1:0] led_short = '0;
  logic [NCH-1:0] led_gnd = '0;
  logic [7:0] sys_flt = 8'h00;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  wire logic dim;
  wire logic sync;
  logic [31:0] rdat;
  logic ack;
  logic [NCH-1:0] pwm;
  logic [NCH-1:0] sink_en;
  logic [NCH-1:0] loop_mask;
  logic [NCH*CUR_W-1:0] scale;
  logic int_o;
  logic int_oe;
  logic on;
  logic pump_on;
  logic ext_sel;
  logic spread;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // ==========================================================
  // Clock, timeout
  always #2 clk = ~clk;
  // Ceiling sits well above two start-up windows plus traffic
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  blc_top #(.PWM_W(PW)) blc_top_inst (.i_clk(clk), .i_nrst(nrst),
    .i_boost_sync_clk(sync), .i_boost_sync_lvl(sync), .i_en(en), .i_dim_in(dim),
    .i_string_count_select(strings), .i_pump_tied(pump_tied), .i_pump_cap_det(cap_det),
    .i_pump_fault(pump_flt), .i_led_open(led_open), .i_led_short(led_short),
    .i_led_gnd(led_gnd), .i_sys_fault(sys_flt), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_sink_pwm(pwm), .o_sink_en(sink_en), .o_boost_loop_mask(loop_mask),
    .o_chan_scale(scale), .o_fault_int_o(int_o), .o_fault_int_oe(int_oe),
    .o_blocks_on(on), .o_pump_on(pump_on), .o_boost_ext_clk_sel(ext_sel),
    .o_spread_on(spread));

  blc_host_model #(.PER(1 << PW)) blc_host_model_inst (.i_clk(clk), .i_sync_run(sync_run),
    .i_sync_lvl(sync_lvl), .i_duty(duty), .o_dim(dim), .o_sync(sync));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Classic single cycle; the request holds until ack is sampled high
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask : rdc

  // Raise enable and poll until the start-up window is over
  task automatic power_up(input logic ext);
    logic [31:0] q;
    sync_run <= ext;
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 1500; i++) begin
      wb_cycle(ADR_STA, 1'b0, 32'h0, q);
      if (q[S_RUN] === 1'b1) break;
    end
    sync_run <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : power_up

  // Cycles until the next rising edge of one channel's drive
  task automatic wait_rise(input int ch, output int t);
    logic p;
    t = 0;
    do begin
      p = pwm[ch];
      @(posedge clk);
      t++;
    end while (!(p === 1'b0 && pwm[ch] === 1'b1) && t < 600);
  endtask : wait_rise

  // ==========================================================
  // Scenarios
  task automatic t_disabled;
    wr(ADR_BRT, 32'h1234);
    wr(ADR_SRC, 32'h1);
    sys_flt <= 8'h01;
    repeat (6) @(posedge clk);
    sys_flt <= 8'h00;
    rdc(ADR_BRT, 32'h0);
    check({int_oe, on}, 2'b00);
  endtask : t_disabled

  task automatic t_start_ext;
    power_up(1'b1);
    rdc(ADR_BRT, {16'h0, RST_BRT});
    rdc(ADR_SRC, {31'h0, RST_SRC});
    rdc(ADR_FST, 32'h0);
    rdc(ADR_STA, 32'h0000_0417);
    check({on, pump_on, ext_sel, spread, sink_en}, {4'b1110, 6'h0f});
  endtask : t_start_ext

  task automatic t_phase;
    int t;
    int n;
    repeat (600) @(posedge clk);
    wait_rise(0, t);
    wait_rise(1, t);
    check(t, (1 << PW) / 4);
    check(pwm[5:4], 2'b00);
    wr(ADR_BRT, 32'h0);
    wr(ADR_SRC, 32'h1);
    n = 0;
    repeat (600) @(posedge clk);
    repeat (300) begin
      @(posedge clk);
      if (pwm !== 6'h00) n++;
    end
    check(n, 0);
    wr(ADR_SRC, 32'h0);
  endtask : t_phase

  task automatic t_led_fault;
    led_open <= 6'h20;
    repeat (6) @(posedge clk);
    rdc(ADR_FST, 32'h0);
    check(int_oe, 1'b0);
    led_open <= 6'h02;
    repeat (6) @(posedge clk);
    rdc(ADR_FST, 32'h1 << F_OPEN);
    check({int_o, int_oe, loop_mask}, {2'b01, 6'h0d});
    led_open <= 6'h00;
    repeat (3) @(posedge clk);
    wr(ADR_FST, 32'h1 << F_OPEN);
    repeat (3) @(posedge clk);
    rdc(ADR_FST, 32'h0);
    check(int_oe, 1'b0);
    // Short on channel 0 leaves the boost loop; ground faults on channels 2 and unused 5
    led_short <= 6'h01;
    led_gnd <= 6'h24;
    repeat (6) @(posedge clk);
    rdc(ADR_FST, (32'h1 << F_SHORT) | (32'h1 << F_GND));
    check(loop_mask, 6'h0e);
    led_short <= 6'h00;
    led_gnd <= 6'h00;
    repeat (3) @(posedge clk);
    wr(ADR_FST, (32'h1 << F_SHORT) | (32'h1 << F_GND));
    rdc(ADR_FST, 32'h0);
  endtask : t_led_fault

  task automatic t_pump;
    wr(ADR_FEN, 32'h7ff);
    pump_flt <= 1'b1;
    repeat (6) @(posedge clk);
    pump_flt <= 1'b0;
    rdc(ADR_FST, 32'h1 << F_PUMP);
    check(int_oe, 1'b0);
    wr(ADR_FEN, 32'hfff);
    repeat (3) @(posedge clk);
    check(int_oe, 1'b1);
    wr(ADR_FST, 32'h1 << F_PUMP);
    repeat (3) @(posedge clk);
    check(int_oe, 1'b0);
  endtask : t_pump

  task automatic t_scale;
    wr(8'h28, 32'hffff_f123);
    rdc(8'h28, 32'h123);
    check(scale[35:24], 12'h123);
    check(scale[11:0], RST_CUR);
    rdc(8'h3c, 32'h0);
  endtask : t_scale

  // Enable falling edge wipes latched faults; restart on a static high strap
  task automatic t_en_fall;
    sys_flt <= 8'h80;
    repeat (6) @(posedge clk);
    rdc(ADR_FST, 32'h1 << (F_SYS + 7));
    sys_flt <= 8'h00;
    en <= 1'b0;
    repeat (6) @(posedge clk);
    check({on, int_oe}, 2'b00);
    strings <= 3'h6;
    pump_tied <= 1'b1;
    sync_lvl <= 1'b1;
    power_up(1'b0);
    rdc(ADR_FST, 32'h0);
    rdc(ADR_STA, 32'h0000_0618);
    check({on, pump_on, ext_sel, spread, sink_en}, {4'b1001, 6'h3f});
  endtask : t_en_fall

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_disabled();
    t_start_ext();
    t_phase();
    t_led_fault();
    t_pump();
    t_scale();
    t_en_fall();
    complete_run();
  end
endmodule : blc_top_tb
`default_nettype wire
